// ---- core/ocs_pkg.sv ----
// Purpose: constants and types shared by the oscillator clock select block
// Assumes: 32-bit AHB-Lite register access, one aligned word per register
// Notes:   printed offsets are register indexes; byte address is index * 4
package ocs_pkg;

    // register indexes as printed, byte address is four times the index
    localparam logic [15:0] OCS_IDX_TB_CFG   = 16'h001d;
    localparam logic [15:0] OCS_IDX_OPTION   = 16'hffcf;
    localparam logic [15:0] OCS_IDX_STATUS   = 16'h0020;
    localparam int          OCS_IDX_LSB      = 2;
    localparam int          OCS_IDX_MSB      = 17;

    // timebase_clock_config fields
    localparam int          OCS_TB_SEL_HI    = 7;
    localparam int          OCS_TB_SEL_LO    = 6;
    localparam int          OCS_STOP_XT_KEEP = 2;
    localparam int          OCS_STOP_RC_KEEP = 1;
    localparam int          OCS_STOP_INT_OFF = 0;
    localparam logic [7:0]  OCS_TB_CFG_RST   = 8'h00;
    localparam logic [7:0]  OCS_TB_CFG_MASK  = 8'hc7;

    // option_select_register fields
    localparam int          OCS_REF_SEL_HI   = 7;
    localparam int          OCS_REF_SEL_LO   = 6;

    // status register fields
    localparam int          OCS_ST_REF_LO    = 0;
    localparam int          OCS_ST_INT_EN    = 2;
    localparam int          OCS_ST_RC_EN     = 3;
    localparam int          OCS_ST_XT_EN     = 4;
    localparam int          OCS_ST_STOPPED   = 5;
    localparam int          OCS_ST_LOADED    = 6;

    // main reference source codes
    localparam logic [1:0]  OCS_REF_NONE     = 2'h0;
    localparam logic [1:0]  OCS_REF_INT      = 2'h1;
    localparam logic [1:0]  OCS_REF_RC       = 2'h2;
    localparam logic [1:0]  OCS_REF_XTAL     = 2'h3;

    // timebase source codes
    localparam logic [1:0]  OCS_TB_INT       = 2'h0;
    localparam logic [1:0]  OCS_TB_RC        = 2'h1;
    localparam logic [1:0]  OCS_TB_XTAL      = 2'h2;
    localparam logic [1:0]  OCS_TB_NONE      = 2'h3;

    localparam logic [1:0]  OCS_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0]
    {
        OCS_RUN  = 3'h1,
        OCS_WAIT = 3'h2,
        OCS_STOP = 3'h4
    } ocs_mode_t;

endpackage : ocs_pkg

// ---- core/ocs_ctrl_if.sv ----
// Purpose: control and clock signals between register side and gating unit
// Assumes: all clocks are levels sampled on hclk
// Notes:   ctrl side drives selections, gate side returns gated levels
`timescale 1ns/1ps
interface ocs_ctrl_if;
    logic [1:0] ref_sel;
    logic [1:0] tb_sel;
    logic       stopped;
    logic       stop_int_off;
    logic       stop_rc_keep;
    logic       stop_xt_keep;
    logic       osc_en;
    logic       int_clk;
    logic       osc_in;
    logic       bus_clk;
    logic       int_en;
    logic       rc_en;
    logic       xt_en;
    logic       main_clk;
    logic       tb_clk;
    logic       wdog_clk;
    logic       out_pin;

    modport ctrl (output ref_sel, tb_sel, stopped, stop_int_off,
                  stop_rc_keep, stop_xt_keep, osc_en, int_clk, osc_in,
                  bus_clk,
                  input  int_en, rc_en, xt_en, main_clk, tb_clk, wdog_clk,
                  out_pin);
    modport gate (input  ref_sel, tb_sel, stopped, stop_int_off,
                  stop_rc_keep, stop_xt_keep, osc_en, int_clk, osc_in,
                  bus_clk,
                  output int_en, rc_en, xt_en, main_clk, tb_clk, wdog_clk,
                  out_pin);
endinterface : ocs_ctrl_if

// ---- core/ocs_gate.sv ----
// Purpose: oscillator enables and reference clock selection
// Assumes: reference selection is stable, loaded once after reset; tb_sel follows register writes
// Notes:   purely combinational; the top registers every result
`timescale 1ns/1ps
module ocs_gate
    import ocs_pkg::*;
(
    ocs_ctrl_if.gate bus
);
    wire int_run;
    wire rc_run;
    wire xt_run;
    wire int_gated;
    wire rc_gated;
    wire xt_gated;

    // internal oscillator runs while osc_en is high unless told off for stop
    assign int_run   = bus.osc_en & ~(bus.stopped & bus.stop_int_off);
    // shared input pin: only the selected one of rc and crystal may run
    assign rc_run    = bus.osc_en & (bus.ref_sel == OCS_REF_RC)
                     & ~(bus.stopped & ~bus.stop_rc_keep);
    assign xt_run    = bus.osc_en & (bus.ref_sel == OCS_REF_XTAL)
                     & ~(bus.stopped & ~bus.stop_xt_keep);
    assign int_gated = bus.int_clk & int_run;
    assign rc_gated  = bus.osc_in & rc_run;
    assign xt_gated  = bus.osc_in & xt_run;

    assign bus.int_en   = int_run;
    assign bus.rc_en    = rc_run;
    assign bus.xt_en    = xt_run;
    assign bus.wdog_clk = int_gated;

    assign bus.main_clk =
        (bus.ref_sel == OCS_REF_INT)  ? int_gated :
        (bus.ref_sel == OCS_REF_RC)   ? rc_gated  :
        (bus.ref_sel == OCS_REF_XTAL) ? xt_gated  : 1'b0;

    // rc and crystal only reach the timebase when they are the main source
    assign bus.tb_clk =
        (bus.tb_sel == OCS_TB_INT)  ? int_gated :
        (bus.tb_sel == OCS_TB_RC)   ? rc_gated  :
        (bus.tb_sel == OCS_TB_XTAL) ? xt_gated  : 1'b0;

    assign bus.out_pin = (bus.ref_sel == OCS_REF_XTAL)
                       ? (~bus.osc_in & xt_run) : bus.bus_clk;
endmodule : ocs_gate

// ---- core/ocs_top.sv ----
// Purpose: oscillator reference clock select with AHB-Lite register access
// Assumes: clock inputs are levels synchronous to hclk; one word per reg
// Notes:   option bits are loaded once after reset and never change after
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module ocs_top
    import ocs_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  option_bits,
    input  wire logic        internal_osc_clock,
    input  wire logic        osc_in_pin,
    input  wire logic        bus_clock,
    input  wire logic        osc_enable_from_sysint,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    input  wire logic        break_state,
    output logic             main_ref_clock,
    output logic             pll_ref_clock,
    output logic             timebase_ref_clock,
    output logic             watchdog_ref_clock,
    output logic             osc_out_pin,
    output logic             internal_osc_en,
    output logic             rc_osc_en,
    output logic             crystal_osc_en
);
    ocs_ctrl_if ctl ();

    logic [7:0]  tb_cfg;
    logic [7:0]  option_select_register;
    logic        option_loaded;
    ocs_mode_t   mode;
    ocs_mode_t   next_mode;
    logic [2:0]  stop_bits;
    logic        dp_write;
    logic        dp_active;
    logic [15:0] dp_index;

    function automatic logic [31:0] ocs_word(input logic [7:0] b);
        ocs_word = {24'h000000, b};
    endfunction : ocs_word

    // bus decode
    wire         addr_take  = hsel & hready & htrans[1];
    wire [15:0]  addr_index = haddr[OCS_IDX_MSB:OCS_IDX_LSB];
    wire         wr_cfg     = dp_active & dp_write
                            & (dp_index == OCS_IDX_TB_CFG);
    wire [7:0]   status_val =
        {1'b0, option_loaded, mode == OCS_STOP, ctl.xt_en, ctl.rc_en,
         ctl.int_en, ctl.ref_sel};
    wire [31:0]  rd_val =
        (addr_index == OCS_IDX_TB_CFG) ? ocs_word(tb_cfg) :
        (addr_index == OCS_IDX_OPTION) ? ocs_word(option_select_register) :
        (addr_index == OCS_IDX_STATUS) ? ocs_word(status_val) : 32'h00000000;
    wire         rd_take    = addr_take & ~hwrite;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_active <= 1'b0;
            dp_write  <= 1'b0;
            dp_index  <= 16'h0000;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            dp_active <= addr_take;
            dp_write  <= hwrite;
            dp_index  <= addr_index;
            hrdata    <= rd_take ? rd_val : 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tb_cfg <= OCS_TB_CFG_RST;
        else if (wr_cfg)
            tb_cfg <= hwdata[7:0] & OCS_TB_CFG_MASK;
    end

    // option bits caught once, the clock after reset release, then frozen
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            option_select_register <= 8'h00;
            option_loaded          <= 1'b0;
        end
        else if (!option_loaded)
        begin
            option_select_register <= option_bits;
            option_loaded          <= 1'b1;
        end
    end

    // stop bits are latched on stop entry; later writes do not apply
    always_comb
    begin
        next_mode = mode;
        case (mode)
            OCS_RUN:  next_mode = stop_mode ? OCS_STOP
                                : (wait_mode ? OCS_WAIT : OCS_RUN);
            OCS_WAIT: next_mode = stop_mode ? OCS_STOP
                                : (wait_mode ? OCS_WAIT : OCS_RUN);
            OCS_STOP: next_mode = stop_mode ? OCS_STOP : OCS_RUN;
            default:  next_mode = OCS_RUN;
        endcase
    end

    wire stop_entry = (next_mode == OCS_STOP) & (mode != OCS_STOP);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode      <= OCS_RUN;
            stop_bits <= 3'h0;
        end
        else
        begin
            mode <= next_mode;
            if (stop_entry)
                stop_bits <= tb_cfg[OCS_STOP_XT_KEEP:OCS_STOP_INT_OFF];
        end
    end

    assign ctl.ref_sel      = option_select_register[OCS_REF_SEL_HI:
                                                     OCS_REF_SEL_LO];
    assign ctl.tb_sel       = tb_cfg[OCS_TB_SEL_HI:OCS_TB_SEL_LO];
    assign ctl.stopped      = (mode == OCS_STOP);
    assign ctl.stop_int_off = stop_bits[OCS_STOP_INT_OFF];
    assign ctl.stop_rc_keep = stop_bits[OCS_STOP_RC_KEEP];
    assign ctl.stop_xt_keep = stop_bits[OCS_STOP_XT_KEEP];
    assign ctl.osc_en       = osc_enable_from_sysint;
    assign ctl.int_clk      = internal_osc_clock;
    assign ctl.osc_in       = osc_in_pin;
    assign ctl.bus_clk      = bus_clock;

    ocs_gate u_gate
    (
        .bus (ctl.gate)
    );

    // break state deliberately has no path into the clock gating
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            main_ref_clock     <= 1'b0;
            pll_ref_clock      <= 1'b0;
            timebase_ref_clock <= 1'b0;
            watchdog_ref_clock <= 1'b0;
            osc_out_pin        <= 1'b0;
            internal_osc_en    <= 1'b0;
            rc_osc_en          <= 1'b0;
            crystal_osc_en     <= 1'b0;
        end
        else
        begin
            main_ref_clock     <= ctl.main_clk;
            pll_ref_clock      <= ctl.main_clk;
            timebase_ref_clock <= ctl.tb_clk;
            watchdog_ref_clock <= ctl.wdog_clk;
            osc_out_pin        <= ctl.out_pin;
            internal_osc_en    <= ctl.int_en;
            rc_osc_en          <= ctl.rc_en;
            crystal_osc_en     <= ctl.xt_en;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    main_sel_int_a: assert property (
        (ctl.ref_sel == OCS_REF_INT) && osc_enable_from_sysint
        && !ctl.stopped |=> main_ref_clock == $past(internal_osc_clock))
        else $error("main reference does not follow internal oscillator");

    tb_sel_none_a: assert property (
        ctl.tb_sel == OCS_TB_NONE |=> !timebase_ref_clock)
        else $error("unused timebase code produced a clock");

    tb_gate_a: assert property (
        (ctl.tb_sel == OCS_TB_RC) && (ctl.ref_sel != OCS_REF_RC)
        |=> !timebase_ref_clock)
        else $error("rc clock reached timebase while not main source");

    int_run_a: assert property (
        osc_enable_from_sysint && !ctl.stopped |=> internal_osc_en)
        else $error("internal oscillator stopped while running");

    rc_xt_excl_a: assert property (
        !(rc_osc_en && crystal_osc_en))
        else $error("rc and crystal oscillators enabled together");

    osc_out_a: assert property (
        option_loaded && (ctl.ref_sel != OCS_REF_XTAL)
        |=> osc_out_pin == $past(bus_clock))
        else $error("output pin not carrying bus clock");

    pll_copy_a: assert property (
        pll_ref_clock == main_ref_clock)
        else $error("pll reference differs from main reference");

    wdog_int_a: assert property (
        osc_enable_from_sysint && !ctl.stopped
        |=> watchdog_ref_clock == $past(internal_osc_clock))
        else $error("watchdog reference not internal oscillator");

    sysint_off_a: assert property (
        !osc_enable_from_sysint |=> !internal_osc_en && !rc_osc_en
        && !crystal_osc_en)
        else $error("oscillator enabled while system enable low");

    wait_keep_a: assert property (
        (mode == OCS_WAIT) && osc_enable_from_sysint
        && (ctl.ref_sel == OCS_REF_RC) |=> rc_osc_en)
        else $error("wait mode halted rc oscillator");

    stop_halt_a: assert property (
        ctl.stopped && !ctl.stop_xt_keep |=> !crystal_osc_en)
        else $error("crystal kept running in stop without keep bit");

    int_stop_a: assert property (
        ctl.stopped && ctl.stop_int_off |=> !internal_osc_en)
        else $error("internal oscillator not halted in stop");

    brk_run_a: assert property (
        break_state && (ctl.ref_sel == OCS_REF_INT) && !ctl.stopped
        && osc_enable_from_sysint
        |=> main_ref_clock == $past(internal_osc_clock))
        else $error("main reference lost in break state");

    sel_hold_a: assert property (
        option_loaded |=> $stable(option_select_register))
        else $error("option selection changed during operation");

    rc_stop_a: assert property (
        ctl.stopped && !ctl.stop_rc_keep |=> !rc_osc_en)
        else $error("rc oscillator kept running in stop without keep bit");

    xt_keep_a: assert property (
        ctl.stopped && ctl.stop_xt_keep && osc_enable_from_sysint
        && (ctl.ref_sel == OCS_REF_XTAL) |=> crystal_osc_en)
        else $error("crystal halted in stop despite keep bit");

    stop_hold_a: assert property (
        mode == OCS_STOP |=> $stable(stop_bits))
        else $error("stop bits changed while stopped");

    int_keep_a: assert property (
        ctl.stopped && !ctl.stop_int_off && osc_enable_from_sysint
        |=> internal_osc_en)
        else $error("internal oscillator halted in stop without off bit");

    xt_out_a: assert property (
        ctl.ref_sel == OCS_REF_XTAL
        |=> osc_out_pin == (!$past(osc_in_pin) && crystal_osc_en))
        else $error("output pin not carrying inverted crystal amplifier");

    xt_tb_gate_a: assert property (
        (ctl.tb_sel == OCS_TB_XTAL) && (ctl.ref_sel != OCS_REF_XTAL)
        |=> !timebase_ref_clock)
        else $error("crystal clock reached timebase while not main source");

    wait_main_a: assert property (
        (mode == OCS_WAIT) && osc_enable_from_sysint
        && (ctl.ref_sel == OCS_REF_XTAL)
        |=> crystal_osc_en && (main_ref_clock == $past(osc_in_pin)))
        else $error("wait mode stopped the main reference clock");

    bus_okay_a: assert property (
        hreadyout && !hresp)
        else $error("register bus not ready or not okay");

endmodule : ocs_top

// ---- tb/ocs_far_model.sv ----
// Purpose: far-side oscillator circuits feeding the select block
// Assumes: levels change by non-blocking assignment after hclk edges
// Notes:   a stopped source toggles every cycle so no stale level hides
`timescale 1ns/1ps
module ocs_far_model
(
    input  wire logic hclk,
    input  wire logic int_en,
    input  wire logic rc_en,
    input  wire logic xt_en,
    output logic      int_clk,
    output logic      osc_in
);
    int cnt = 0;
    initial int_clk = 1'b0;
    initial osc_in = 1'b0;
    // the loose internal source only paces, nothing here relies on it
    always @(posedge hclk)
    begin
        cnt <= cnt + 1;
        int_clk <= int_en ? cnt[1] : ~int_clk;
        if (xt_en)
            osc_in <= cnt[2];
        else if (rc_en)
            osc_in <= cnt[0];
        else
            osc_in <= ~osc_in;
    end
endmodule : ocs_far_model

// ---- tb/oscillator_clock_select_tb.sv ----
// Purpose: self-checking bench for the oscillator clock select block
// Assumes: outputs settle four cycles after any mode or config change
// Notes:   clock outputs are checked only in steady windows
`timescale 1ns/1ps
module oscillator_clock_select_tb
    import ocs_pkg::*;
;
    localparam logic [31:0] A_CFG = {14'h0, OCS_IDX_TB_CFG, 2'h0};
    localparam logic [31:0] A_OPT = {14'h0, OCS_IDX_OPTION, 2'h0};
    localparam logic [31:0] A_ST  = {14'h0, OCS_IDX_STATUS, 2'h0};
    localparam logic [31:0] A_BAD = 32'h0000_0040;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        hreadyout, hresp, int_clk, osc_in;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic [7:0]  opt = 8'h40;
    logic        bus_clk = 1'b0;
    logic        osc_en = 1'b1;
    logic        wt = 1'b0;
    logic        stp = 1'b0;
    logic        brk = 1'b0;
    logic        main_c, pll_c, tb_c, wd_c, out_p, en_i, en_r, en_x;
    logic        chk_on = 1'b0;
    logic        p_int, p_in, p_bus;
    logic [15:0] lf = 16'hb314; // seed 45844
    logic [7:0]  cfg = 8'h00;
    logic [7:0]  stop_cfg = 8'h00;
    logic [1:0]  ref_s = 2'h0;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    wire         e_i = osc_en & ~(stp & stop_cfg[0]);
    wire         e_r = osc_en & (ref_s == OCS_REF_RC) & (~stp | stop_cfg[1]);
    wire         e_x = osc_en & (ref_s == OCS_REF_XTAL) & (~stp | stop_cfg[2]);

    ocs_top u_ocs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .option_bits(opt),
        .internal_osc_clock(int_clk), .osc_in_pin(osc_in),
        .bus_clock(bus_clk), .osc_enable_from_sysint(osc_en),
        .wait_mode(wt), .stop_mode(stp), .break_state(brk),
        .main_ref_clock(main_c), .pll_ref_clock(pll_c),
        .timebase_ref_clock(tb_c), .watchdog_ref_clock(wd_c),
        .osc_out_pin(out_p), .internal_osc_en(en_i), .rc_osc_en(en_r),
        .crystal_osc_en(en_x));

    ocs_far_model u_ocs_far_model (.hclk(hclk), .int_en(en_i),
        .rc_en(en_r), .xt_en(en_x), .int_clk(int_clk), .osc_in(osc_in));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // expected level of a source, gated by its modelled enable
    function automatic logic src(input logic [1:0] c);
        case (c)
            OCS_REF_INT:  src = p_int & e_i;
            OCS_REF_RC:   src = p_in & e_r;
            OCS_REF_XTAL: src = p_in & e_x;
            default:      src = 1'b0;
        endcase
    endfunction : src

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= OCS_HTRANS_NONSEQ;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        r = hrdata;
        check(hresp, 32'h0);
    endtask : bus

    task automatic wr_cfg(input logic [7:0] v);
        bus(1'b1, A_CFG, {lf, 8'h0, v}, rd);
        cfg = v & OCS_TB_CFG_MASK;
        bus(1'b0, A_CFG, 32'h0, rd);
        check(rd, {24'h0, cfg});
    endtask : wr_cfg

    task automatic run(input int n);
        repeat (4) @(posedge hclk);
        chk_on <= 1'b1;
        repeat (n) @(posedge hclk);
        chk_on <= 1'b0;
    endtask : run

    initial
    begin
        forever #20 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        lf <= lfsr(lf);
        bus_clk <= lf[0];
        if (hresetn)
            check({hreadyout, en_r & en_x}, 32'h2);
        if (chk_on)
        begin
            check(main_c, src(ref_s));
            check(pll_c, src(ref_s));
            check(tb_c, src(cfg[7:6] + 2'h1));
            check(wd_c, p_int & e_i);
            check({en_i, en_r, en_x}, {e_i, e_r, e_x});
            check(out_p, (ref_s == OCS_REF_XTAL) ? ~p_in & e_x : p_bus);
        end
        p_int = int_clk;
        p_in = osc_in;
        p_bus = bus_clk;
        if (cyc == 40000)
        begin
            n_errors++;
            close_out();
        end
    end

    initial
    begin
        for (int r = 0; r < 4; r++)
        begin
            hresetn <= 1'b0;
            opt <= {r[1:0], 6'h15};
            repeat (8) @(posedge hclk);
            // expectations move only once the checker has been switched off
            ref_s = r[1:0];
            cfg = 8'h00;
            hresetn <= 1'b1;
            @(posedge hclk);
            // option byte is loaded by now; later changes must not matter
            opt <= lf[7:0];
            bus(1'b0, A_CFG, 32'h0, rd);
            check(rd, {24'h0, OCS_TB_CFG_RST});
            bus(1'b1, A_OPT, 32'hffff_ffff, rd);
            bus(1'b0, A_OPT, 32'h0, rd);
            check(rd & 32'hc0, {24'h0, r[1:0], 6'h0});
            bus(1'b0, A_ST, 32'h0, rd);
            check(rd & 32'h43, {26'h1, 4'h0, r[1:0]});
            for (int t = 0; t < 4; t++)
            begin
                wr_cfg({t[1:0], lf[5:0]});
                run(20);
            end
            for (int m = 0; m < 3; m++)
            begin
                {wt, brk, osc_en} <= 3'(9'b101_011_000 >> (m * 3));
                run(16);
                {wt, brk, osc_en} <= 3'b001;
                run(8);
            end
            for (int s = 0; s < 8; s++)
            begin
                wr_cfg({cfg[7:6], 3'h0, s[2:0]});
                stop_cfg = cfg;
                stp <= 1'b1;
                run(12);
                // bits written while stopped take effect only next entry
                wr_cfg({cfg[7:6], 3'h0, ~s[2:0]});
                run(12);
                stp <= 1'b0;
                run(8);
            end
        end
        bus(1'b1, A_BAD, {lf, lf}, rd);
        bus(1'b0, A_BAD, 32'h0, rd);
        check(rd, 32'h0);
        close_out();
    end
endmodule : oscillator_clock_select_tb
